// ===== include/duad_pkg.sv
/*
 * Package for the dual serial channel address and interrupt decoder:
 * address map constants, interrupt codes, request and select carriers.
 * Assumes a 16-bit byte-wide I/O space and a 4-bit rotary switch value.
 */
package duad_pkg;

	// ----------------------------------------------------------------
	// Widths and counts
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam int ID_W = 4;
	localparam int CHAN_N = 2;

	// ----------------------------------------------------------------
	// Switch values and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] ID_RESET = 4'h0;
	localparam logic [3:0] ID_LAST_COMPAT = 4'h3;
	localparam logic [3:0] ID_FIRST_RSVD = 4'hE;

	// ----------------------------------------------------------------
	// Address map
	// ----------------------------------------------------------------
	localparam logic [15:0] BASE_PORT_THREE = 16'h03E8;
	localparam logic [15:0] BASE_PORT_FOUR = 16'h02E8;
	localparam logic [15:0] BASE_ENH_A = 16'h01A0;
	localparam logic [15:0] BASE_ENH_B = 16'h02A0;
	localparam logic [15:0] BASE_ALT_A = 16'h01C0;
	localparam logic [15:0] BASE_ALT_B = 16'h02C0;
	localparam logic [15:0] BASE_ENH_8 = 16'h9800;
	localparam logic [15:0] BASE_ENH_9 = 16'h9820;
	localparam logic [15:0] BASE_ENH_A2 = 16'h9840;
	localparam logic [15:0] BASE_ENH_B2 = 16'h9860;
	localparam logic [15:0] BASE_ENH_C = 16'h0700;
	localparam logic [15:0] BASE_ENH_D = 16'h0720;
	localparam logic [15:0] SECOND_OFS = 16'h0008;
	localparam logic [15:0] VECTOR_OFS = 16'h001F;
	localparam int WIN_LSB = 3;

	// ----------------------------------------------------------------
	// Interrupt line codes
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		IRQ_NONE = 3'h0,
		IRQ_L5 = 3'h1,
		IRQ_L7 = 3'h2,
		IRQ_L9 = 3'h3,
		IRQ_L10 = 3'h4
	} duad_irq_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
	} duad_req_t;

	typedef struct packed {
		logic first;
		logic second;
		logic vector;
		logic rd;
		logic wr;
		logic [2:0] offset;
	} duad_sel_t;

	typedef struct packed {
		logic irq5;
		logic irq7;
		logic irq9;
		logic irq10;
	} duad_lines_t;

	typedef struct packed {
		logic valid;
		logic enhanced;
		logic [15:0] base0;
		logic [15:0] base1;
		duad_irq_t irq0;
		duad_irq_t irq1;
	} duad_map_t;

endpackage

// ===== logic/duad_decoder.sv
/*
 * Address decode and interrupt routing for a two channel serial module.
 * Assumes host strobes are synchronous one-cycle pulses on core_clk and
 * that the rotary switch and host family strap are static while running.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - Switch ID 0-3 gives compatible mode, 4-D enhanced, fixed maps.
// - Compatible: first channel at 03E8-03EF, second at 02E8-02EF.
// - Compatible: IRQ5 first, IRQ7 second; ID picks which lines drive.
// - Enhanced: channels share one line by ID; IDs 9, A split; B none.
// - Enhanced: first channel at ID base, second at base plus 8.
// - Alternate host: IDs 4-7 at 01C0/02C0, IDs 8 and C use IRQ10.
// - The ID reads as 0 until captured, the compatible default.
// - Enhanced: vector register at base plus 1Fh shows requesters.
module duad_decoder #(
	parameter int CHANNELS = duad_pkg::CHAN_N
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// Switch and strap
	input wire logic [3:0] switch_id,
	input wire logic alt_host,
	// Host byte bus
	input wire duad_pkg::duad_req_t host_req,
	// Channel interrupt requests
	input wire logic [1:0] chan_irq,
	// Decoded selects
	output duad_pkg::duad_sel_t chan_sel,
	// Vector read data
	output logic [7:0] rd_data,
	output logic rd_valid,
	// Interrupt lines
	output duad_pkg::duad_lines_t irq_lines,
	// Status
	output logic mode_enh,
	output logic cfg_ready
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (CHANNELS != duad_pkg::CHAN_N) begin : g_bad_chan
		$error("Only two channels are supported");
	end

	// ----------------------------------------------------------------
	// Map lookup
	// ----------------------------------------------------------------
	function automatic duad_pkg::duad_map_t map_of(input logic [3:0] id,
			input logic alt);
		duad_pkg::duad_map_t m;
		logic [15:0] b;
		m = '0;
		b = '0;
		m.valid = 1'b1;
		m.enhanced = (id > duad_pkg::ID_LAST_COMPAT);
		case (id)
			4'h0, 4'h1, 4'h2, 4'h3: begin
				m.base0 = duad_pkg::BASE_PORT_THREE;
				m.base1 = duad_pkg::BASE_PORT_FOUR;
				m.irq0 = (id == 4'h1 || id == 4'h0) ? duad_pkg::IRQ_L5
					: duad_pkg::IRQ_NONE;
				m.irq1 = (id == 4'h2 || id == 4'h0) ? duad_pkg::IRQ_L7
					: duad_pkg::IRQ_NONE;
			end
			4'h4, 4'h5, 4'h6, 4'h7: begin
				if (alt) begin
					b = id[1] ? duad_pkg::BASE_ALT_B : duad_pkg::BASE_ALT_A;
				end else begin
					b = id[1] ? duad_pkg::BASE_ENH_B : duad_pkg::BASE_ENH_A;
				end
				m.irq0 = id[0] ? duad_pkg::IRQ_L7 : duad_pkg::IRQ_L5;
				m.irq1 = m.irq0;
			end
			4'h8: begin
				b = duad_pkg::BASE_ENH_8;
				m.irq0 = alt ? duad_pkg::IRQ_L10 : duad_pkg::IRQ_L9;
				m.irq1 = m.irq0;
			end
			4'h9: begin
				b = duad_pkg::BASE_ENH_9;
				m.irq0 = duad_pkg::IRQ_L5;
				m.irq1 = duad_pkg::IRQ_L7;
			end
			4'hA: begin
				b = duad_pkg::BASE_ENH_A2;
				m.irq0 = duad_pkg::IRQ_L7;
				m.irq1 = duad_pkg::IRQ_L9;
			end
			4'hB: begin
				b = duad_pkg::BASE_ENH_B2;
			end
			4'hC: begin
				b = duad_pkg::BASE_ENH_C;
				m.irq0 = alt ? duad_pkg::IRQ_L10 : duad_pkg::IRQ_L9;
				m.irq1 = m.irq0;
			end
			4'hD: begin
				b = duad_pkg::BASE_ENH_D;
				m.irq0 = duad_pkg::IRQ_L7;
				m.irq1 = duad_pkg::IRQ_L7;
			end
			default: begin
				m = '0;
			end
		endcase
		if (m.enhanced && m.valid) begin
			m.base0 = b;
			m.base1 = b + duad_pkg::SECOND_OFS;
		end
		return m;
	endfunction

	function automatic logic win_hit(input logic [15:0] a,
			input logic [15:0] base);
		return a[15:duad_pkg::WIN_LSB] == base[15:duad_pkg::WIN_LSB];
	endfunction

	// ----------------------------------------------------------------
	// Switch capture
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_CAPTURE = 2'b00,
		ST_RUN = 2'b01
	} duad_state_t;

	duad_state_t state, next_state;
	logic [3:0] cur_id, next_cur_id;
	logic cur_alt, next_cur_alt;

	always_comb begin
		next_state = state;
		next_cur_id = cur_id;
		next_cur_alt = cur_alt;
		case (state)
			ST_CAPTURE: begin
				next_cur_id = switch_id;
				next_cur_alt = alt_host;
				next_state = ST_RUN;
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_CAPTURE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= ST_CAPTURE;
			cur_id <= duad_pkg::ID_RESET;
			cur_alt <= 1'b0;
		end else begin
			state <= next_state;
			cur_id <= next_cur_id;
			cur_alt <= next_cur_alt;
		end
	end

	// ----------------------------------------------------------------
	// Decode and routing
	// ----------------------------------------------------------------
	duad_pkg::duad_map_t map;
	duad_pkg::duad_sel_t next_chan_sel;
	duad_pkg::duad_lines_t next_irq_lines;
	logic [7:0] next_rd_data;
	logic next_rd_valid;
	logic run, acc, vec_hit;

	assign map = map_of(cur_id, cur_alt);
	assign run = (state == ST_RUN);
	// Every access is one byte at one address
	assign acc = run && map.valid && (host_req.rd || host_req.wr);
	assign vec_hit = map.enhanced
		&& host_req.addr == map.base0 + duad_pkg::VECTOR_OFS;

	always_comb begin
		next_chan_sel = '0;
		next_chan_sel.rd = host_req.rd;
		next_chan_sel.wr = host_req.wr;
		next_chan_sel.offset = host_req.addr[2:0];
		if (acc) begin
			next_chan_sel.first = win_hit(host_req.addr, map.base0);
			next_chan_sel.second = win_hit(host_req.addr, map.base1);
			next_chan_sel.vector = vec_hit;
		end
		if (!(next_chan_sel.first || next_chan_sel.second
				|| next_chan_sel.vector)) begin
			next_chan_sel.rd = 1'b0;
			next_chan_sel.wr = 1'b0;
		end
		next_rd_valid = acc && vec_hit && host_req.rd;
		next_rd_data = next_rd_valid ? {6'h00, chan_irq} : 8'h00;
		next_irq_lines = '0;
		if (run) begin
			for (int c = 0; c < 2; c++) begin
				case (c == 0 ? map.irq0 : map.irq1)
					duad_pkg::IRQ_L5: next_irq_lines.irq5 |= chan_irq[c];
					duad_pkg::IRQ_L7: next_irq_lines.irq7 |= chan_irq[c];
					duad_pkg::IRQ_L9: next_irq_lines.irq9 |= chan_irq[c];
					duad_pkg::IRQ_L10: next_irq_lines.irq10 |= chan_irq[c];
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			chan_sel <= '0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			irq_lines <= '0;
			mode_enh <= 1'b0;
			cfg_ready <= 1'b0;
		end else begin
			chan_sel <= next_chan_sel;
			rd_data <= next_rd_data;
			rd_valid <= next_rd_valid;
			irq_lines <= next_irq_lines;
			mode_enh <= map.enhanced && run;
			cfg_ready <= run;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	a_mode_from_id: assert property (
			run && cur_id <= 4'h3 |=> !mode_enh)
		else $error("Compatible ID shows enhanced mode");
	a_compat_decode: assert property (
			run && cur_id <= 4'h3 && host_req.rd
			&& host_req.addr[15:3] == 13'h007D |=> chan_sel.first)
		else $error("Compatible first window not selected");
	a_compat_irq: assert property (
			run && cur_id == 4'h1 && chan_irq == 2'b11
			|=> irq_lines.irq5 && !irq_lines.irq7)
		else $error("ID 1 interrupt lines wrong");
	a_enh_shared: assert property (
			run && cur_id == 4'h5 && chan_irq[1]
			|=> irq_lines.irq7 && !irq_lines.irq5)
		else $error("Shared line not driven");
	a_enh_second: assert property (
			run && cur_id == 4'h8 && host_req.wr
			&& host_req.addr == 16'h9808
			|=> chan_sel.second && chan_sel.wr)
		else $error("Second enhanced window not selected");
	a_alt_map: assert property (
			run && cur_alt && cur_id == 4'hC && chan_irq[0]
			|=> irq_lines.irq10 && !irq_lines.irq9)
		else $error("Alternate host line wrong");
	// Offset follows the address even when nothing is selected
	a_reserved_quiet: assert property (
			run && cur_id >= 4'hE
			|=> {chan_sel.first, chan_sel.second, chan_sel.vector,
			chan_sel.rd, chan_sel.wr} == 5'h00 && irq_lines == '0)
		else $error("Reserved ID is active");
	a_default_id: assert property (
			state == ST_CAPTURE |-> cur_id == 4'h0 && !cfg_ready)
		else $error("ID not at default before capture");
	a_vector_read: assert property (
			run && map.enhanced && host_req.rd
			&& host_req.addr == map.base0 + duad_pkg::VECTOR_OFS
			|=> rd_valid && rd_data[1:0] == $past(chan_irq))
		else $error("Vector read wrong");

	c_compat_rd: cover property (run && !map.enhanced ##1 chan_sel.first);
	c_enh_vec: cover property (rd_valid);
	c_alt_irq10: cover property (irq_lines.irq10);

endmodule

// ===== test/duad_decoder_bench.sv
/*
 * Self-checking bench for the address and interrupt decoder.
 * Assumes the package is compiled first and the switch is static
 * between resets.
 */
`timescale 1ns/1ps

module duad_decoder_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] switch_id = 4'h0;
	logic alt_host = 1'b0;
	logic [1:0] chan_irq = 2'h0;
	duad_pkg::duad_req_t host_req;
	duad_pkg::duad_sel_t chan_sel;
	logic [7:0] rd_data;
	logic rd_valid;
	duad_pkg::duad_lines_t irq_lines;
	logic mode_enh;
	logic cfg_ready;
	int num_errors = 0;
	int checked = 0;
	int seed = 32'h9A03210E;
	logic [22:0] got;
	logic [22:0] notes[$];
	logic pend = 1'b0;
	logic [15:0] base0, base1;
	logic [3:0] m0, m1;
	logic valid, enh;

	always #2 core_clk = ~core_clk;

	duad_decoder duad_decoder_inst (.core_clk(core_clk), .reset_n(reset_n),
		.switch_id(switch_id), .alt_host(alt_host), .host_req(host_req),
		.chan_irq(chan_irq), .chan_sel(chan_sel), .rd_data(rd_data),
		.rd_valid(rd_valid), .irq_lines(irq_lines), .mode_enh(mode_enh),
		.cfg_ready(cfg_ready));

	duad_host_model duad_host_model_inst (.core_clk(core_clk),
		.host_req(host_req));

	// Outputs in the order of a note
	assign got = {chan_sel, rd_valid, rd_data, irq_lines, mode_enh,
		cfg_ready};

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic check(input logic [22:0] g, input logic [22:0] e);
		checked++;
		if (g !== e) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d, errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Answer registers on the taking edge, checked half a cycle later
	always @(posedge core_clk) pend <= host_req.rd | host_req.wr;

	always @(negedge core_clk) begin
		if (pend === 1'b1) begin
			if (notes.size() == 0) begin
				num_errors++;
				$display("Error at %0t: got %h expected %h", $time, 1, 0);
			end else begin
				check(got, notes.pop_front());
			end
		end
	end

	// ----------------------------------------------------------------
	// Expected map
	// ----------------------------------------------------------------
	task automatic set_map(input logic [3:0] id, input logic alt);
		valid = id < 4'hE;
		// Reserved IDs show compatible mode
		enh = id > 4'h3 && id < 4'hE;
		m0 = 4'h0;
		m1 = 4'h0;
		base0 = 16'h03E8;
		case (id)
		4'h0: begin m0 = 4'h8; m1 = 4'h4; end
		4'h1: m0 = 4'h8;
		4'h2: m1 = 4'h4;
		4'h4, 4'h5: base0 = alt ? 16'h01C0 : 16'h01A0;
		4'h6, 4'h7: base0 = alt ? 16'h02C0 : 16'h02A0;
		4'h8, 4'h9, 4'hA, 4'hB: base0 = 16'h9800 + {9'h000, id[1:0], 5'h00};
		4'hC: base0 = 16'h0700;
		4'hD: base0 = 16'h0720;
		default: ;
		endcase
		base1 = enh ? base0 + 16'h0008 : 16'h02E8;
		case (id)
		4'h4, 4'h6: m0 = 4'h8;
		4'h5, 4'h7, 4'hD: m0 = 4'h4;
		4'h8, 4'hC: m0 = alt ? 4'h1 : 4'h2;
		default: ;
		endcase
		if (enh) m1 = m0;
		if (id == 4'h9) begin m0 = 4'h8; m1 = 4'h4; end
		if (id == 4'hA) begin m0 = 4'h4; m1 = 4'h2; end
	endtask

	// Notes the expected answer, then issues the transfer
	task automatic access(input logic [15:0] a, input logic r);
		logic f, s, v, h, rv;
		f = valid && a[15:3] == base0[15:3];
		s = valid && a[15:3] == base1[15:3];
		v = valid && enh && a == base0 + 16'h001F;
		h = f | s | v;
		rv = v & r;
		notes.push_back({f, s, v, h & r, h & !r, a[2:0], rv,
			rv ? {6'h00, chan_irq} : 8'h00,
			({4{chan_irq[0]}} & m0) | ({4{chan_irq[1]}} & m1), enh, 1'b1});
		duad_host_model_inst.put(a, r);
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] rnd;
		for (int i = 0; i < 32; i++) begin
			@(posedge core_clk);
			reset_n <= 1'b0;
			switch_id <= i[3:0];
			alt_host <= i[4];
			chan_irq <= 2'h3;
			set_map(i[3:0], i[4]);
			repeat (3) @(posedge core_clk);
			#1;
			check(got, 23'h000000);
			@(posedge core_clk) reset_n <= 1'b1;
			repeat (2) @(posedge core_clk);
			for (int k = 0; k < 4; k++) begin
				chan_irq <= k[1:0];
				@(posedge core_clk);
				rnd = $random(seed);
				access(base0 + {13'h0000, rnd[2:0]}, rnd[3]);
				access(base1 + {13'h0000, rnd[6:4]}, rnd[7]);
				access(base0 + 16'h001F, rnd[9]);
				access(base0 + 16'h0010, rnd[8]);
				duad_host_model_inst.idle();
			end
		end
		repeat (2) @(posedge core_clk);
		close_out();
	end

	// Cuts a hang short
	initial begin
		#40000;
		num_errors++;
		close_out();
	end
endmodule

// ===== test/duad_host_model.sv
/*
 * Host side model: issues byte-wide I/O reads and writes to the decoder.
 * Assumes the bench calls put and idle from one process, one per edge.
 */
`timescale 1ns/1ps

module duad_host_model (
	// Clock
	input wire logic core_clk,
	// Host byte bus
	output duad_pkg::duad_req_t host_req
);
	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	initial host_req = '0;

	// One byte transfer per edge, never wider
	task automatic put(input logic [15:0] a, input logic r);
		@(posedge core_clk);
		host_req <= '{addr: a, rd: r, wr: !r};
	endtask

	// Released bus shows the inverse of the last address
	task automatic idle();
		@(posedge core_clk);
		host_req <= '{addr: ~host_req.addr, rd: 1'b0, wr: 1'b0};
	endtask
endmodule
